// ==== hw/nar_pkg.sv ====
package nar_pkg;

    localparam logic [7:0]  OFS_CHIP_ID    = 8'h00;
    localparam logic [7:0]  OFS_NODE_ADDR  = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h80;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h84;

    // bit n of the printed layout is word bit 31-n
    localparam int          BUS_ID_LSB     = 22;
    localparam int          NODE_ID_LSB    = 16;
    localparam int          ROOT_BIT       = 15;
    localparam int          ACK_CODE_LSB   = 4;
    localparam int          ACK_VALID_BIT  = 0;
    localparam int          VERSION_LSB    = 16;

    localparam logic [31:0] NODE_ADDR_RST  = 32'hFFFF_0000;
    localparam logic [9:0]  BUS_ID_RST     = 10'h3FF;
    localparam logic [5:0]  NODE_ID_RST    = 6'h3F;
    localparam logic [9:0]  BCAST_BUS_ID   = 10'h3FF;
    localparam logic [5:0]  BCAST_NODE_ID  = 6'h3F;
    localparam logic [4:0]  ACK_TIMEOUT    = 5'h10;
    localparam logic [4:0]  ACK_PKT_ERROR  = 5'h13;

    localparam int          IRQ_W          = 5;
    localparam int          IRQ_ACK_RX     = 0;
    localparam int          IRQ_ACK_TMO    = 1;
    localparam int          IRQ_ACK_ERR    = 2;
    localparam int          IRQ_PHY_UPD    = 3;
    localparam int          IRQ_REARB      = 4;

    typedef struct packed {
        logic [9:0] bus_id;
        logic [5:0] node_id;
    } nar_node_addr_t;

    typedef struct packed {
        logic       valid;
        logic       root;
        logic [5:0] phy_assigned_id;
    } nar_phy_stat_t;

    typedef struct packed {
        logic       rx;
        logic       timeout;
        logic       error;
        logic [3:0] code;
    } nar_ack_evt_t;

    typedef struct packed {
        logic [9:0]       local_bus_id;
        logic [5:0]       local_node_id;
        logic             root;
        logic [4:0]       last_tx_ack_code;
        logic             ack_code_valid;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic             bus_ack;
        logic [31:0]      rdata;
        logic             rx_accept;
        logic             rearb;
    } nar_state_t;

    localparam nar_state_t STATE_RST = '{
        local_bus_id:     BUS_ID_RST,
        local_node_id:    NODE_ID_RST,
        root:             1'b0,
        last_tx_ack_code: 5'h00,
        ack_code_valid:   1'b0,
        irq_stat:         5'h00,
        irq_mask:         5'h00,
        bus_ack:          1'b0,
        rdata:            32'h0000_0000,
        rx_accept:        1'b0,
        rearb:            1'b0
    };

endpackage : nar_pkg

// ==== hw/nar_regs.sv ====
// Design decision made here: the Avalon-MM register port.
module nar_regs #(
    parameter logic [15:0] VERSION_CODE  = 16'h0A01, // arbitrary value
    parameter logic [15:0] REVISION_CODE = 16'h0001  // arbitrary value
) (
    input  wire logic                    mclk_i,
    input  wire logic                    arst_n_i,
    input  wire logic [7:0]              avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic      [31:0]             avs_readdata_o,
    output logic                         avs_waitrequest_o,
    input  wire logic                    diag_write_unlock_i,
    input  wire nar_pkg::nar_phy_stat_t  phy_stat_i,
    input  wire nar_pkg::nar_ack_evt_t   ack_evt_i,
    input  wire logic                    tx_done_interrupt_i,
    input  wire logic                    tx_nonbroadcast_i,
    input  wire nar_pkg::nar_node_addr_t rx_dest_i,
    output logic                         rx_accept_o,
    output nar_pkg::nar_node_addr_t      src_addr_o,
    output logic                         rearbitrate_o,
    output logic                         irq_o
);

    nar_pkg::nar_state_t state_reg;
    nar_pkg::nar_state_t state_next;

    logic        req;
    logic        take;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic [31:0] cur_word;

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    function automatic logic [31:0] node_word(input nar_pkg::nar_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[nar_pkg::BUS_ID_LSB +: 10]  = s.local_bus_id;
        w[nar_pkg::NODE_ID_LSB +: 6]  = s.local_node_id;
        w[nar_pkg::ROOT_BIT]          = s.root;
        w[nar_pkg::ACK_CODE_LSB +: 5] = s.last_tx_ack_code;
        w[nar_pkg::ACK_VALID_BIT]     = s.ack_code_valid;
        node_word = w;
    endfunction : node_word

    function automatic logic addr_match(input nar_pkg::nar_state_t s,
                                        input nar_pkg::nar_node_addr_t d);
        addr_match = ((d.bus_id == s.local_bus_id) || (d.bus_id == nar_pkg::BCAST_BUS_ID)) &&
                     ((d.node_id == s.local_node_id) || (d.node_id == nar_pkg::BCAST_NODE_ID));
    endfunction : addr_match

    function automatic logic [31:0] read_mux(input nar_pkg::nar_state_t s,
                                             input logic [7:0] a);
        case (a)
            nar_pkg::OFS_CHIP_ID:   read_mux = {VERSION_CODE, REVISION_CODE};
            nar_pkg::OFS_NODE_ADDR: read_mux = node_word(s);
            nar_pkg::OFS_IRQ_STAT:  read_mux = {27'h0, s.irq_stat};
            nar_pkg::OFS_IRQ_MASK:  read_mux = {27'h0, s.irq_mask};
            default:                read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    always_comb begin
        state_next = state_reg;
        req        = avs_read_i | avs_write_i;
        take       = req & state_reg.bus_ack;
        wmask      = be_mask(avs_byteenable_i);
        cur_word   = (avs_address_i == nar_pkg::OFS_IRQ_MASK) ? {27'h0, state_reg.irq_mask}
                                                              : node_word(state_reg);
        merged     = (cur_word & ~wmask) | (avs_writedata_i & wmask);

        // one wait cycle, then accept; read data captured in the wait cycle
        state_next.bus_ack = req & ~state_reg.bus_ack;
        state_next.rdata   = (avs_read_i & ~state_reg.bus_ack) ?
                             read_mux(state_reg, avs_address_i) : 32'h0000_0000;

        if (take && avs_write_i) begin
            case (avs_address_i)
                nar_pkg::OFS_NODE_ADDR: begin
                    state_next.local_bus_id  = merged[nar_pkg::BUS_ID_LSB +: 10];
                    state_next.local_node_id = merged[nar_pkg::NODE_ID_LSB +: 6];
                    if (diag_write_unlock_i) begin
                        state_next.last_tx_ack_code = merged[nar_pkg::ACK_CODE_LSB +: 5];
                    end
                end
                nar_pkg::OFS_IRQ_MASK: begin
                    state_next.irq_mask = merged[nar_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // clear only what the captured read data showed, so later events survive
        if (take && avs_read_i) begin
            case (avs_address_i)
                nar_pkg::OFS_NODE_ADDR: begin
                    if (state_reg.rdata[nar_pkg::ACK_VALID_BIT]) begin
                        state_next.ack_code_valid = 1'b0;
                    end
                end
                nar_pkg::OFS_IRQ_STAT: begin
                    state_next.irq_stat = state_next.irq_stat &
                                          ~state_reg.rdata[nar_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // hardware updates after software so they win
        if (phy_stat_i.valid) begin
            state_next.local_node_id = phy_stat_i.phy_assigned_id;
            state_next.root          = phy_stat_i.root;
            state_next.irq_stat[nar_pkg::IRQ_PHY_UPD] = 1'b1;
        end

        if (ack_evt_i.error) begin
            state_next.last_tx_ack_code = nar_pkg::ACK_PKT_ERROR;
            state_next.ack_code_valid   = 1'b1;
            state_next.irq_stat[nar_pkg::IRQ_ACK_ERR] = 1'b1;
        end else if (ack_evt_i.timeout) begin
            state_next.last_tx_ack_code = nar_pkg::ACK_TIMEOUT;
            state_next.ack_code_valid   = 1'b1;
            state_next.irq_stat[nar_pkg::IRQ_ACK_TMO] = 1'b1;
        end else if (ack_evt_i.rx) begin
            state_next.last_tx_ack_code = {1'b0, ack_evt_i.code};
            state_next.ack_code_valid   = 1'b1;
            state_next.irq_stat[nar_pkg::IRQ_ACK_RX] = 1'b1;
        end

        state_next.rearb = tx_done_interrupt_i & tx_nonbroadcast_i &
                           ~state_reg.ack_code_valid;
        if (state_next.rearb) begin
            state_next.irq_stat[nar_pkg::IRQ_REARB] = 1'b1;
        end

        state_next.rx_accept = addr_match(state_reg, rx_dest_i);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= nar_pkg::STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_waitrequest_o  = (avs_read_i | avs_write_i) & ~state_reg.bus_ack;
    assign avs_readdata_o     = state_reg.rdata;
    assign rx_accept_o        = state_reg.rx_accept;
    assign src_addr_o         = '{bus_id:  state_reg.local_bus_id,
                                  node_id: state_reg.local_node_id};
    assign rearbitrate_o      = state_reg.rearb;
    assign irq_o              = |(state_reg.irq_stat & state_reg.irq_mask);

    logic no_ack_evt;
    assign no_ack_evt = ~(ack_evt_i.rx | ack_evt_i.timeout | ack_evt_i.error);

    a_id_constant: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (take && avs_read_i && avs_address_i == nar_pkg::OFS_CHIP_ID)
        |-> avs_readdata_o == {VERSION_CODE, REVISION_CODE})
        else $error("identification word wrong");

    a_reset_value: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(arst_n_i) |-> node_word(state_reg) == nar_pkg::NODE_ADDR_RST)
        else $error("node word reset value wrong");

    a_bus_id_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (take && avs_write_i && avs_address_i == nar_pkg::OFS_NODE_ADDR &&
         avs_byteenable_i == 4'hF)
        |=> state_reg.local_bus_id == $past(avs_writedata_i[nar_pkg::BUS_ID_LSB +: 10]))
        else $error("bus id write lost");

    a_ack_locked: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!diag_write_unlock_i && no_ack_evt) |=> $stable(state_reg.last_tx_ack_code))
        else $error("ack code changed while locked");

    a_phy_update: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        phy_stat_i.valid |=> (state_reg.local_node_id == $past(phy_stat_i.phy_assigned_id))
                             && (state_reg.root == $past(phy_stat_i.root)))
        else $error("phy status not applied");

    a_rx_filter: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (rx_dest_i.bus_id == nar_pkg::BCAST_BUS_ID && rx_dest_i.node_id == nar_pkg::BCAST_NODE_ID)
        |=> rx_accept_o)
        else $error("broadcast destination rejected");

    a_ack_timeout: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (ack_evt_i.timeout && !ack_evt_i.error)
        |=> state_reg.last_tx_ack_code == nar_pkg::ACK_TIMEOUT && state_reg.ack_code_valid)
        else $error("timeout code missing");

    a_ack_normal: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (ack_evt_i.rx && !ack_evt_i.timeout && !ack_evt_i.error)
        |=> state_reg.last_tx_ack_code == {1'b0, $past(ack_evt_i.code)}
            && state_reg.ack_code_valid)
        else $error("received ack not recorded");

    a_read_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (take && avs_read_i && avs_address_i == nar_pkg::OFS_NODE_ADDR && no_ack_evt &&
         avs_readdata_o[nar_pkg::ACK_VALID_BIT])
        |=> !state_reg.ack_code_valid)
        else $error("ack valid not cleared by read");

    a_rearb_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (tx_done_interrupt_i && tx_nonbroadcast_i && !state_reg.ack_code_valid)
        |=> rearbitrate_o)
        else $error("re-arbitration not requested");

    a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (take && avs_read_i && avs_address_i == nar_pkg::OFS_NODE_ADDR)
        |-> avs_readdata_o[14:9] == 6'h00 && avs_readdata_o[3:1] == 3'h0)
        else $error("reserved bits not zero");

    a_wait_bound: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(avs_waitrequest_o) |=> !avs_waitrequest_o)
        else $error("waitrequest held too long");

    a_rx_local: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (rx_dest_i == src_addr_o) |=> rx_accept_o)
        else $error("own address rejected");

    a_rearb_quiet: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !(tx_done_interrupt_i && tx_nonbroadcast_i && !state_reg.ack_code_valid)
        |=> !rearbitrate_o)
        else $error("spurious re-arbitration");

    c_read_clear: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        take && avs_read_i && avs_address_i == nar_pkg::OFS_NODE_ADDR && state_reg.ack_code_valid);
    c_phy_vs_write: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        phy_stat_i.valid && take && avs_write_i && avs_address_i == nar_pkg::OFS_NODE_ADDR);
    c_rearb: cover property (@(posedge mclk_i) disable iff (!arst_n_i) rearbitrate_o);
    c_irq: cover property (@(posedge mclk_i) disable iff (!arst_n_i) irq_o);

endmodule : nar_regs

// ==== bench/nar_phy_model.sv ====
module nar_phy_model (
    input  wire logic              mclk_i,
    output nar_pkg::nar_phy_stat_t phy_stat_o,
    output nar_pkg::nar_ack_evt_t  ack_evt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        phy_stat_o = '0;
        ack_evt_o  = '0;
    end

    // one register 0 status transfer; idle fields show the inverse afterwards
    task automatic send_status(input logic root, input logic [5:0] id);
        phy_stat_o <= '{valid: 1'b1, root: root, phy_assigned_id: id};
        @(posedge mclk_i);
        phy_stat_o <= '{valid: 1'b0, root: ~root, phy_assigned_id: ~id};
        @(posedge mclk_i);
    endtask : send_status

    // kind 0 ack received, 1 ack timeout, 2 ack packet error
    task automatic send_ack(input int kind, input logic [3:0] code);
        ack_evt_o <= '{rx: kind == 0, timeout: kind == 1, error: kind == 2, code: code};
        @(posedge mclk_i);
        ack_evt_o <= '{rx: 1'b0, timeout: 1'b0, error: 1'b0, code: ~code};
        @(posedge mclk_i);
    endtask : send_ack
endmodule : nar_phy_model

// ==== bench/node_address_ack_status_regs_tb.sv ====
module node_address_ack_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] VER = 16'h5A21; // arbitrary value
    localparam logic [15:0] REV = 16'h0007; // arbitrary value

    logic                    mclk_i, arst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [7:0]              avs_address_i;
    logic [31:0]             avs_writedata_i, avs_readdata_o, rdata, d;
    logic [3:0]              avs_byteenable_i;
    logic                    diag_write_unlock_i, tx_done_interrupt_i, tx_nonbroadcast_i;
    logic                    rx_accept_o, rearbitrate_o, irq_o, exp_root, exp_v;
    nar_pkg::nar_phy_stat_t  phy_stat_i;
    nar_pkg::nar_ack_evt_t   ack_evt_i;
    nar_pkg::nar_node_addr_t rx_dest_i, src_addr_o, dst;
    logic [9:0]              exp_bus;
    logic [5:0]              exp_node;
    logic [4:0]              exp_ack;
    int                      bad_count, checks_done;

    nar_regs #(.VERSION_CODE(VER), .REVISION_CODE(REV)) uut (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .diag_write_unlock_i(diag_write_unlock_i),
        .phy_stat_i(phy_stat_i), .ack_evt_i(ack_evt_i), .tx_done_interrupt_i(tx_done_interrupt_i),
        .tx_nonbroadcast_i(tx_nonbroadcast_i), .rx_dest_i(rx_dest_i), .rx_accept_o(rx_accept_o),
        .src_addr_o(src_addr_o), .rearbitrate_o(rearbitrate_o), .irq_o(irq_o));

    nar_phy_model phy (.mclk_i(mclk_i), .phy_stat_o(phy_stat_i), .ack_evt_o(ack_evt_i));

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] node_word();
        return {exp_bus, exp_node, exp_root, 6'h00, exp_ack, 3'h0, exp_v};
    endfunction : node_word

    function automatic logic accepts(nar_pkg::nar_node_addr_t t);
        return (t.bus_id == exp_bus || t.bus_id == 10'h3FF) &&
               (t.node_id == exp_node || t.node_id == 6'h3F);
    endfunction : accepts

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // entered and left right after a rising edge; waitrequest judged at the edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        avs_writedata_i <= wd;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 16);
        if (avs_waitrequest_o !== 1'b0) begin
            bad_count++;
            $display("BAD at %0t: bus wait timed out", $time);
            print_verdict();
        end else begin
            rdata = avs_readdata_o;
            avs_read_i  <= 1'b0;
            avs_write_i <= 1'b0;
            @(posedge mclk_i);
        end
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
    endtask : rd_chk

    // 0 irq, 1 rearbitrate, 2 receive accept; looked at mid cycle
    task automatic flag(input int which, input logic exp);
        logic g;
        @(negedge mclk_i);
        g = which == 0 ? irq_o : which == 1 ? rearbitrate_o : rx_accept_o;
        chk({31'h0, g}, {31'h0, exp});
        @(posedge mclk_i);
    endtask : flag

    task automatic tx_done(input logic exp);
        tx_done_interrupt_i <= 1'b1;
        @(posedge mclk_i);
        tx_done_interrupt_i <= 1'b0;
        flag(1, exp);
    endtask : tx_done

    initial begin
        {avs_read_i, avs_write_i, diag_write_unlock_i, tx_done_interrupt_i} = 4'h0;
        avs_address_i = 8'h00;
        avs_writedata_i = 32'h0000_0000;
        avs_byteenable_i = 4'hF;
        tx_nonbroadcast_i = 1'b1;
        rx_dest_i = '0;
        arst_n_i = 1'b0;
        {bad_count, checks_done} = 0;
        {exp_bus, exp_node, exp_root, exp_ack, exp_v} = {10'h3FF, 6'h3F, 1'b0, 5'h00, 1'b0};
        void'($urandom(32'hF735));
        repeat (12) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd_chk(nar_pkg::OFS_CHIP_ID, {VER, REV});
        bus(1'b1, nar_pkg::OFS_CHIP_ID, 32'hFFFF_FFFF);
        rd_chk(nar_pkg::OFS_CHIP_ID, {VER, REV});
        rd_chk(nar_pkg::OFS_NODE_ADDR, 32'hFFFF_0000);
        rd_chk(8'h10, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            d = $urandom() & 32'hFFFF_FFFE;
            diag_write_unlock_i <= i[0];
            bus(1'b1, nar_pkg::OFS_NODE_ADDR, d);
            {exp_bus, exp_node} = d[31:16];
            if (i[0]) exp_ack = d[8:4];
            rd_chk(nar_pkg::OFS_NODE_ADDR, node_word());
            chk({16'h0000, src_addr_o}, {16'h0000, exp_bus, exp_node});
        end
        diag_write_unlock_i <= 1'b0;
        avs_byteenable_i <= 4'h8;
        d = $urandom();
        bus(1'b1, nar_pkg::OFS_NODE_ADDR, d);
        avs_byteenable_i <= 4'hF;
        exp_bus[9:2] = d[31:24];
        rd_chk(nar_pkg::OFS_NODE_ADDR, node_word());
        for (int i = 0; i < 3; i++) begin
            d = $urandom();
            phy.send_status(i[0], d[5:0]);
            {exp_root, exp_node} = {i[0], d[5:0]};
            rd_chk(nar_pkg::OFS_NODE_ADDR, node_word());
        end
        d = $urandom();
        fork
            bus(1'b1, nar_pkg::OFS_NODE_ADDR, d);
            begin
                @(posedge mclk_i);
                phy.send_status(1'b1, ~d[21:16]);
            end
        join
        {exp_bus, exp_root, exp_node} = {d[31:22], 1'b1, ~d[21:16]};
        rd_chk(nar_pkg::OFS_NODE_ADDR, node_word());
        for (int k = 0; k < 3; k++) begin
            d = $urandom();
            phy.send_ack(k, d[3:0]);
            exp_ack = k == 0 ? {1'b0, d[3:0]} : k == 1 ? 5'h10 : 5'h13;
            exp_v = 1'b1;
            rd_chk(nar_pkg::OFS_NODE_ADDR, node_word());
            exp_v = 1'b0;
            rd_chk(nar_pkg::OFS_NODE_ADDR, node_word());
        end
        bus(1'b1, nar_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        bus(1'b0, nar_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        phy.send_status(exp_root, exp_node);
        flag(0, 1'b0);
        phy.send_ack(0, 4'h2);
        {exp_ack, exp_v} = {5'h02, 1'b1};
        flag(0, 1'b1);
        rd_chk(nar_pkg::OFS_IRQ_STAT, 32'h0000_0009);
        flag(0, 1'b0);
        tx_done(1'b0);
        rd_chk(nar_pkg::OFS_NODE_ADDR, node_word());
        exp_v = 1'b0;
        tx_done(1'b1);
        tx_nonbroadcast_i <= 1'b0;
        tx_done(1'b0);
        tx_nonbroadcast_i <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            d = $urandom();
            dst = d[15:0];
            if (i % 4 == 1) dst.bus_id = 10'h3FF;
            if (i % 4 == 2) dst.node_id = 6'h3F;
            if (i % 4 == 3) dst = {exp_bus, exp_node};
            rx_dest_i <= dst;
            @(posedge mclk_i);
            flag(2, accepts(dst));
        end
        arst_n_i <= 1'b0;
        @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        {exp_bus, exp_node, exp_root, exp_ack, exp_v} = {10'h3FF, 6'h3F, 1'b0, 5'h00, 1'b0};
        rd_chk(nar_pkg::OFS_NODE_ADDR, node_word());
        chk({16'h0000, src_addr_o}, {16'h0000, exp_bus, exp_node});
        flag(0, 1'b0);
        print_verdict();
    end
endmodule : node_address_ack_status_regs_tb
